// file: inc/lph_pkg.sv
package lph_pkg;
    // Bus and word widths
    localparam int BUS_W = 18;
    localparam int ADDR_W = 16;
    localparam int CMD_W = 8;
    // Display RAM extents
    localparam logic [15:0] H_ADDR_MAX = 16'h00EF;
    localparam logic [15:0] V_ADDR_MAX = 16'h013F;
    localparam logic [9:0] SRC_LAST = 10'h2CF;
    localparam logic [8:0] GATE_LAST = 9'h13F;
    // Lane positions
    localparam int HI_LANE_LSB = 10;
    localparam int LO_LANE_LSB = 1;
    localparam int NINE_HI_LSB = 9;
    // Reset values
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [17:0] WORD_RST = 18'h00000;
    // One-hot access states
    typedef enum logic [3:0] {
        LPH_IDLE = 4'h1,
        LPH_WRITE = 4'h2,
        LPH_READ = 4'h4,
        LPH_DONE = 4'h8
    } lph_state_e;
    // Bus width decoded from the select pins
    typedef enum logic [1:0] {
        LPH_W16 = 2'h0,
        LPH_W8 = 2'h1,
        LPH_W18 = 2'h2,
        LPH_W9 = 2'h3
    } lph_width_e;

    // Width from the select pins (bit 3 picks 18/9 family, bit 0 narrow)
    function automatic lph_width_e lph_width(input logic [3:0] sel);
        lph_width = lph_width_e'({sel[3], sel[0]});
    endfunction

    // Place a host-side word on the write lanes
    function automatic logic [17:0] lph_pack_wr(input lph_width_e w, input logic [17:0] v);
        case (w)
            LPH_W16: lph_pack_wr = {v[15:8], 1'b0, v[7:0], 1'b0};
            LPH_W8: lph_pack_wr = {v[7:0], 10'h000};
            LPH_W9: lph_pack_wr = {v[8:0], 9'h000};
            default: lph_pack_wr = v;
        endcase
    endfunction

    // Take a word off the write lanes
    function automatic logic [17:0] lph_unpack_wr(input lph_width_e w, input logic [17:0] d);
        case (w)
            LPH_W16: lph_unpack_wr = {2'h0, d[17:10], d[8:1]};
            LPH_W8: lph_unpack_wr = {10'h000, d[17:10]};
            LPH_W9: lph_unpack_wr = {9'h000, d[17:9]};
            default: lph_unpack_wr = d;
        endcase
    endfunction

    // Place a device word on the read lanes
    function automatic logic [17:0] lph_pack_rd(input lph_width_e w, input logic [17:0] v);
        case (w)
            LPH_W16: lph_pack_rd = {v[15:8], 1'b0, v[7:0], 1'b0};
            LPH_W8: lph_pack_rd = {9'h000, v[7:0], 1'b0};
            LPH_W9: lph_pack_rd = {9'h000, v[8:0]};
            default: lph_pack_rd = v;
        endcase
    endfunction

    // Take a word off the read lanes
    function automatic logic [17:0] lph_unpack_rd(input lph_width_e w, input logic [17:0] d);
        case (w)
            LPH_W16: lph_unpack_rd = {2'h0, d[17:10], d[8:1]};
            LPH_W8: lph_unpack_rd = {10'h000, d[8:1]};
            LPH_W9: lph_unpack_rd = {9'h000, d[8:0]};
            default: lph_unpack_rd = d;
        endcase
    endfunction
endpackage

// file: inc/lph_bus_if.sv
interface lph_bus_if;
    // Static mode pins, strapped by the host side
    logic [3:0] iface_sel;
    // Strobes and selects
    logic cs_n;
    logic dc;
    logic rw_wr_n; // R/W in 6800, write strobe in 8080
    logic e_rd_n; // E in 6800, read strobe in 8080
    // Split data bus, each end with its own enable
    logic [17:0] host_d;
    logic host_oe;
    logic [17:0] dev_d;
    logic dev_oe;
    logic [17:0] d;

    // Resolved wire: whoever enables wins; contention shows as X
    assign d = (host_oe && dev_oe) ? 18'hXXXXX :
               host_oe ? host_d : dev_oe ? dev_d : 18'h3FFFF;

    modport host (output iface_sel, output cs_n, output dc, output rw_wr_n,
        output e_rd_n, output host_d, output host_oe, input d);
    modport dev (input iface_sel, input cs_n, input dc, input rw_wr_n,
        input e_rd_n, output dev_d, output dev_oe, input d);
endinterface

// file: logic/lph_dev.sv
// Notes on behaviour
// - Select pins choose width and strobe protocol
// - 16-bit uses D[17:10] and D[8:1]
// - 8-bit writes high lanes, reads low
// - 18-bit uses whole bus both ways
// - 9-bit writes D[17:9], reads D[8:0]
// - 6800: CS low, E fall ends transfer
// - 8080: RD or WR low strobes access
// - D/C low command, high data/status
// - Data words bus-wide, commands always 8-bit
// - Host dummy-reads before display data
// - RAM address 0..239 columns, 0..319 rows
// - Source order flips column to source map
// - Colour order swaps red and blue
// - Gate order flips row to gate map
module lph_dev
    import lph_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Host bus
    lph_bus_if.dev bus,
    // Panel mapping controls
    input wire logic source_order_ctrl_in,
    input wire logic colour_order_ctrl_in,
    input wire logic gate_order_ctrl_in,
    // Core side: read source and current address
    input wire logic [7:0] status_in,
    input wire logic [17:0] pixel_rd_in,
    input wire logic [15:0] h_addr_in,
    input wire logic [15:0] v_addr_in,
    // Core side: received accesses
    output logic cmd_valid_out,
    output logic [7:0] cmd_out,
    output logic data_valid_out,
    output logic [17:0] data_out,
    output logic rd_done_out,
    output logic rd_was_data_out,
    // Panel mapping of the current address
    output logic addr_ok_out,
    output logic [9:0] source_out,
    output logic [8:0] gate_out,
    output logic [1:0] sub_order_out
);
    lph_width_e width;
    logic is_8080;
    logic strobe_act;
    logic is_read;
    logic strobe_q;
    logic rd_act_q;
    logic ending;
    logic [17:0] rd_word;
    logic [17:0] wr_word;
    logic wr_close;
    lph_state_e state_q;

    // Pixel read-back is not returned: D/C-high reads give status only,
    // so pixel_rd_in waits for a core that adds display data reads

    // First source of a column's triplet; only the low 8 bits can be in range
    function automatic logic [9:0] triplet_base(input logic [15:0] col);
        triplet_base = {2'h0, col[7:0]} * 10'h003;
    endfunction

    // Mode decode; pins are static so no registering needed
    assign width = lph_width(bus.iface_sel);
    assign is_8080 = bus.iface_sel[1];

    // Strobe active and direction per protocol
    // 6800 E is active high; 8080 accepts exactly one strobe low
    always_comb begin
        if (is_8080) begin
            strobe_act = !bus.cs_n && (bus.e_rd_n ^ bus.rw_wr_n);
            is_read = !bus.e_rd_n && bus.rw_wr_n;
        end else begin
            strobe_act = !bus.cs_n && bus.e_rd_n;
            is_read = bus.rw_wr_n;
        end
    end

    // Transfer ends when the strobe drops (E fall, or RD/WR rise)
    assign ending = strobe_q && !strobe_act;
    assign wr_close = ending && (state_q == LPH_WRITE);
    assign wr_word = lph_unpack_wr(width, bus.d);

    // Strobe history and access state
    // DONE spends one cycle before a new strobe is looked at
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            strobe_q <= 1'b0;
            rd_act_q <= 1'b0;
            state_q <= LPH_IDLE;
        end else if (ce_in) begin
            strobe_q <= strobe_act;
            rd_act_q <= strobe_act && is_read;
            case (state_q)
                LPH_IDLE: begin
                    if (strobe_act) begin
                        state_q <= is_read ? LPH_READ : LPH_WRITE;
                    end
                end
                LPH_WRITE, LPH_READ: begin
                    if (!strobe_act) begin
                        state_q <= LPH_DONE;
                    end
                end
                LPH_DONE: state_q <= LPH_IDLE;
                default: state_q <= LPH_IDLE;
            endcase
        end
    end

    // Command capture on the closing edge; commands stay 8-bit at any width
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_valid_out <= 1'b0;
            cmd_out <= 8'h00;
        end else if (ce_in) begin
            cmd_valid_out <= wr_close && !bus.dc;
            if (wr_close && !bus.dc) begin
                cmd_out <= wr_word[7:0];
            end
        end
    end

    // Display data capture on the closing edge, as wide as the selected bus
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_valid_out <= 1'b0;
            data_out <= WORD_RST;
        end else if (ce_in) begin
            data_valid_out <= wr_close && bus.dc;
            if (wr_close && bus.dc) begin
                data_out <= wr_word;
            end
        end
    end

    // Read word: command echo when D/C low, status otherwise
    always_comb begin
        if (!bus.dc) begin
            rd_word = {10'h000, cmd_out};
        end else begin
            rd_word = {10'h000, status_in};
        end
    end

    // Read lanes driven only inside a live read, never while the host may drive
    // Registered lanes trade a cycle of latency for a clean turnaround
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bus.dev_oe <= 1'b0;
            bus.dev_d <= WORD_RST;
        end else if (ce_in) begin
            bus.dev_oe <= strobe_act && is_read;
            bus.dev_d <= lph_pack_rd(width, rd_word);
        end
    end

    // Read completion; the first data read returns current status like any other, and the host discards it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_done_out <= 1'b0;
            rd_was_data_out <= 1'b0;
        end else if (ce_in) begin
            rd_done_out <= ending && rd_act_q;
            rd_was_data_out <= ending && rd_act_q && bus.dc;
        end
    end

    // Range check of the current RAM address
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_ok_out <= 1'b0;
        end else if (ce_in) begin
            addr_ok_out <= (h_addr_in <= H_ADDR_MAX) && (v_addr_in <= V_ADDR_MAX);
        end
    end

    // First source of the pixel's triplet; junk when out of range, see addr_ok_out
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            source_out <= 10'h000;
        end else if (ce_in) begin
            if (source_order_ctrl_in) begin
                source_out <= triplet_base(h_addr_in);
            end else begin
                source_out <= SRC_LAST - triplet_base(h_addr_in);
            end
        end
    end

    // Gate driven by the current row
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gate_out <= 9'h000;
        end else if (ce_in) begin
            gate_out <= gate_order_ctrl_in ? v_addr_in[8:0] : GATE_LAST - v_addr_in[8:0];
        end
    end

    // Sub-pixel order: 0 puts red first, 2 puts blue first
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sub_order_out <= 2'h0;
        end else if (ce_in) begin
            sub_order_out <= colour_order_ctrl_in ? 2'h2 : 2'h0;
        end
    end
endmodule // lph_dev

// file: logic/lph_host.sv
module lph_host
    import lph_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Mode strap
    input wire logic [3:0] iface_sel_in,
    // Request side
    input wire logic req_in,
    input wire logic req_read_in,
    input wire logic req_dc_in,
    input wire logic [17:0] req_data_in,
    output logic busy_out,
    output logic done_out,
    output logic [17:0] rd_data_out,
    // Bus
    lph_bus_if.host bus
);
    lph_width_e width;
    lph_state_e state_q;
    logic rd_q;

    assign width = lph_width(iface_sel_in);

    // One access: strobe up one cycle, hold one, release
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= LPH_IDLE;
            rd_q <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rd_data_out <= WORD_RST;
            // Strap and idle strobe level follow the pins even in reset, so the
            // mode is settled and steady by the first access
            bus.iface_sel <= iface_sel_in;
            bus.cs_n <= 1'b1;
            bus.dc <= 1'b0;
            bus.rw_wr_n <= 1'b1;
            bus.e_rd_n <= iface_sel_in[1]; // E idles low, RD idles high
            bus.host_d <= WORD_RST;
            bus.host_oe <= 1'b0;
        end else if (ce_in) begin
            bus.iface_sel <= iface_sel_in;
            done_out <= 1'b0;
            case (state_q)
                LPH_IDLE: begin
                    bus.cs_n <= 1'b1;
                    bus.host_oe <= 1'b0;
                    bus.e_rd_n <= !iface_sel_in[1] ? 1'b0 : 1'b1;
                    bus.rw_wr_n <= 1'b1;
                    if (req_in) begin
                        busy_out <= 1'b1;
                        rd_q <= req_read_in;
                        bus.cs_n <= 1'b0;
                        bus.dc <= req_dc_in;
                        bus.host_d <= lph_pack_wr(width, req_data_in);
                        bus.host_oe <= !req_read_in;
                        if (iface_sel_in[1]) begin
                            bus.e_rd_n <= !req_read_in;
                            bus.rw_wr_n <= req_read_in;
                        end else begin
                            bus.rw_wr_n <= req_read_in;
                            bus.e_rd_n <= 1'b1;
                        end
                        state_q <= req_read_in ? LPH_READ : LPH_WRITE;
                    end
                end
                LPH_WRITE, LPH_READ: begin
                    // Close strobe; 8080 by rising RD/WR, 6800 by falling E
                    bus.e_rd_n <= !bus.iface_sel[1] ? 1'b0 : 1'b1;
                    bus.rw_wr_n <= bus.iface_sel[1] ? 1'b1 : rd_q;
                    state_q <= LPH_DONE;
                end
                LPH_DONE: begin
                    // Device lanes lag the strobe by one cycle, so read data lands here
                    if (rd_q) begin
                        rd_data_out <= lph_unpack_rd(width, bus.d);
                    end
                    bus.cs_n <= 1'b1;
                    bus.host_oe <= 1'b0;
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    state_q <= LPH_IDLE;
                end
                default: state_q <= LPH_IDLE;
            endcase
        end
    end
endmodule // lph_host

// file: bench/lph_asserts.sv
module lph_asserts (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Interface signals
    input wire logic [3:0] iface_sel,
    input wire logic cs_n,
    input wire logic dc,
    input wire logic rw_wr_n,
    input wire logic e_rd_n,
    input wire logic [17:0] host_d,
    input wire logic host_oe,
    input wire logic [17:0] dev_d,
    input wire logic dev_oe,
    input wire logic [17:0] d
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // One driver at a time on the shared bus
    a_no_contention: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the bus");
    a_dev_drive_cs: assert property (dev_oe |-> $past(!cs_n))
        else $error("device drives without select");
    a_dev_drive_rd: assert property (dev_oe |-> $past(rw_wr_n))
        else $error("device drives during a write");
    a_host_drive_wr: assert property (host_oe |-> !cs_n && (iface_sel[1] ? e_rd_n : !rw_wr_n))
        else $error("host drives outside a write");
    // Idle levels only checked once the strap has settled
    a_idle_strobes: assert property (cs_n && $stable(iface_sel)
        |-> (iface_sel[1] ? (e_rd_n && rw_wr_n) : !e_rd_n))
        else $error("strobe active while deselected");
    a_single_strobe: assert property (iface_sel[1] |-> (e_rd_n || rw_wr_n))
        else $error("both strobes low");
    a_e_fall_sel: assert property (!iface_sel[1] && $fell(e_rd_n) |-> !cs_n)
        else $error("enable fell without select");
    a_access_bound: assert property ($fell(cs_n) |-> ##[1:4] $rose(cs_n))
        else $error("access too long");
    a_bus_release: assert property ($rose(cs_n) |=> !dev_oe && !host_oe)
        else $error("bus held after access");
    a_mode_steady: assert property (!cs_n |-> $stable(iface_sel))
        else $error("mode changed in access");

    // Main scenarios
    c_read_6800: cover property ($fell(cs_n) && rw_wr_n && !iface_sel[1]);
    c_write_8080: cover property (host_oe && iface_sel[1] && dc);
    c_dev_read: cover property (dev_oe && iface_sel[3]);
endmodule // lph_asserts

// file: bench/test_lcd_parallel_host_interface.sv
module test_lcd_parallel_host_interface;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst_n_in = 0, req_in = 0, req_rd = 0, req_dc = 0;
    logic rl = 0, colour_order_ctrl = 0, tb = 0, done, cmd_valid, data_valid, ok;
    logic ce = 1, busy, rd_done, rd_was;
    logic [3:0] sel = 4'h0;
    logic [7:0] status = 8'h00, cmd;
    logic [15:0] h = 16'h0000, v = 16'h0000;
    logic [17:0] req_data = 18'h00000, rd_data, data;
    logic [9:0] src;
    logic [8:0] gate;
    logic [1:0] sub;
    int error_cnt = 0, compares = 0, n_cmd = 0, n_dat = 0;
    int n_rd = 0, n_rdd = 0;

    always #20 clk_in = ~clk_in;
    // Count valid pulses so lost or doubled ones show
    always @(posedge clk_in) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (data_valid === 1'b1) n_dat++;
        if (rd_done === 1'b1) n_rd++;
        if (rd_was === 1'b1) n_rdd++;
    end

    lph_bus_if u_lph_bus_if();
    lph_host u_lph_host(.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .iface_sel_in(sel),
        .req_in(req_in), .req_read_in(req_rd), .req_dc_in(req_dc), .req_data_in(req_data),
        .busy_out(busy), .done_out(done), .rd_data_out(rd_data), .bus(u_lph_bus_if));
    lph_dev u_lph_dev(.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .bus(u_lph_bus_if),
        .source_order_ctrl_in(rl), .colour_order_ctrl_in(colour_order_ctrl), .gate_order_ctrl_in(tb),
        .status_in(status), .pixel_rd_in(18'h00000), .h_addr_in(h), .v_addr_in(v),
        .cmd_valid_out(cmd_valid), .cmd_out(cmd), .data_valid_out(data_valid), .data_out(data),
        .rd_done_out(rd_done), .rd_was_data_out(rd_was), .addr_ok_out(ok), .source_out(src),
        .gate_out(gate), .sub_order_out(sub));
    lph_asserts u_lph_asserts(.clk_in(clk_in), .rst_n_in(rst_n_in),
        .iface_sel(u_lph_bus_if.iface_sel), .cs_n(u_lph_bus_if.cs_n), .dc(u_lph_bus_if.dc),
        .rw_wr_n(u_lph_bus_if.rw_wr_n), .e_rd_n(u_lph_bus_if.e_rd_n),
        .host_d(u_lph_bus_if.host_d), .host_oe(u_lph_bus_if.host_oe),
        .dev_d(u_lph_bus_if.dev_d), .dev_oe(u_lph_bus_if.dev_oe), .d(u_lph_bus_if.d));

    task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Mask and lane image of a word on the wire
    function automatic logic [35:0] lanes(input logic [3:0] s, input logic rd, input logic [17:0] w);
        case ({s[3], s[0]})
            2'b00: lanes = {18'h3FDFE, w[15:8], 1'b0, w[7:0], 1'b0};
            2'b01: lanes = rd ? {18'h001FE, 9'h000, w[7:0], 1'b0} : {18'h3FC00, w[7:0], 10'h000};
            2'b10: lanes = {18'h3FFFF, w};
            default: lanes = rd ? {18'h001FF, 9'h000, w[8:0]} : {18'h3FE00, w[8:0], 9'h000};
        endcase
    endfunction

    // One host access; wire lanes judged while the driving end is enabled
    task automatic xfer(input logic rd, input logic dcv, input logic [17:0] w, input logic [17:0] ww);
        logic [35:0] ln;
        int n;
        ln = lanes(sel, rd, ww);
        req_in = 1;
        req_rd = rd;
        req_dc = dcv;
        req_data = w;
        @(negedge clk_in);
        req_in = 0;
        check(18'(busy), 18'h00001, "busy in access");
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            if ((rd ? u_lph_bus_if.dev_oe : u_lph_bus_if.host_oe) === 1'b1)
                check(u_lph_bus_if.d & ln[35:18], ln[17:0], "wire lanes");
            @(negedge clk_in);
            n++;
        end
        check(18'(n < 20), 18'h00001, "access done");
        check(18'(busy), 18'h00000, "busy after done");
        repeat (2) @(negedge clk_in);
    endtask

    task automatic t_modes();
        logic [17:0] dv, wm;
        logic [7:0] cv;
        for (int i = 0; i < 8; i++) begin
            sel = {i[2], 1'b0, i[1:0]};
            rst_n_in = 0;
            n_cmd = 0;
            n_dat = 0;
            n_rd = 0;
            n_rdd = 0;
            repeat (2) @(negedge clk_in);
            rst_n_in = 1;
            status = 8'hA5 ^ 8'(i);
            cv = 8'h3C + 8'(i);
            dv = 18'h2B6D9 ^ 18'(i);
            wm = sel[3] ? (sel[0] ? 18'h001FF : 18'h3FFFF) : (sel[0] ? 18'h000FF : 18'h0FFFF);
            xfer(0, 0, {10'h000, cv}, {10'h000, cv});
            check({10'h000, cmd}, {10'h000, cv}, "command");
            xfer(0, 1, dv, dv & wm);
            check(data, dv & wm, "data word");
            xfer(1, 1, 18'h00000, {10'h000, status}); // dummy first read
            xfer(1, 1, 18'h00000, {10'h000, status});
            check(rd_data, {10'h000, status}, "status read");
            xfer(1, 0, 18'h00000, {10'h000, cv});
            check(rd_data, {10'h000, cv}, "command read");
            check({n_cmd[8:0], n_dat[8:0]}, 18'h00201, "write pulses");
            check({n_rd[8:0], n_rdd[8:0]}, 18'h00602, "read pulses");
        end
        $display("modes test done");
    endtask

    task automatic t_map();
        logic [9:0] es;
        for (int i = 0; i < 10; i++) begin
            {tb, colour_order_ctrl, rl} = 3'(i);
            h = 16'(i * 30 - (i >> 3));
            v = 16'(i * 40 - (i >> 3));
            repeat (2) @(negedge clk_in);
            es = rl ? 10'(3 * h) : 10'(719 - 3 * h);
            check({17'h0, ok}, {17'h0, (h <= 16'h00EF) && (v <= 16'h013F)}, "range");
            check({16'h0, sub}, colour_order_ctrl ? 18'h2 : 18'h0, "colour order");
            if (h <= 16'h00EF && v <= 16'h013F) begin
                check({8'h0, src}, {8'h0, es}, "source order");
                check({9'h0, gate}, {9'h0, tb ? 9'(v) : 9'(319 - v)}, "gate order");
            end
        end
        $display("map test done");
    endtask

    // Clock enable low must hold the source register, then release it
    task automatic t_freeze();
        logic [9:0] held;
        ce = 0;
        rl = 1;
        h = 16'h0010;
        held = src;
        repeat (3) @(negedge clk_in);
        check({8'h0, src}, {8'h0, held}, "frozen source");
        ce = 1;
        repeat (2) @(negedge clk_in);
        check({8'h0, src}, 18'h00030, "source after enable");
        $display("freeze test done");
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge clk_in);
        rst_n_in = 1;
        t_modes();
        t_map();
        t_freeze();
        stop_test();
    end
    // Watchdog, far beyond the roughly 250 cycles needed
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
endmodule // test_lcd_parallel_host_interface
